// File: hw/icd_decoder.sv
`include "icd_consts.svh"
module icd_decoder (
    input wire logic sys_clk_in, // 100 MHz clock
    input wire logic sys_rst_in, // Sync reset, high
    input wire logic [3:0] bus_addr_in, // Register byte address
    input wire logic [31:0] bus_wdata_in, // Write data
    input wire logic bus_wr_in, // Write strobe
    input wire logic bus_rd_in, // Read strobe
    output logic [31:0] bus_rdata_out, // Read data, next cycle
    input wire logic ir_load_in, // Load instruction code
    input wire logic [0:12] ir_code_in, // Op-code bits 0-12
    input wire logic ir_clear_in, // Clear register, await code
    input wire logic illegal_in, // User illegal attempt
    output logic [0:12] instruction_reg_out, // Register contents
    output logic [7:0] class_out, // One-hot class level
    output logic unimplemented_user_op_out, // Trap command level
    output logic unused_op_out, // Unused class 001 code
    output logic [3:0] fp_op_out, // Float op one-hot
    output logic [4:0] char_op_out, // Character ops
    output logic float_scale_out, // Floating scale
    output logic normalize_round_gate_out, // Rounding gate
    output logic [3:0] mode_out, // Mode one-hot
    output logic fullword_out, // Full-word transfer
    output logic swap_out, // Full-word swap
    output logic negate_out, // Full-word negate
    output logic mul_out, // Fixed multiply
    output logic div_out, // Fixed divide
    output logic mul_div_out, // Shared mul/div level
    output logic div_int_out, // Divide integer
    output logic div_frac_out, // Divide fraction
    output logic mul_frac_gate_out, // Bit 6 true
    output logic mul_int_gate_out, // Bit 6 false
    output logic [7:0] shift_op_out, // Shift group
    output logic [7:0] misc_op_out, // Misc group
    output logic jump_restore_instr_out, // Gated jump-restore
    output logic [7:0] jump_group_out, // Jump group
    output logic jump_any_out, // Jumping members
    output logic store_misc_out, // Flag-storing members
    output logic add_out, // Fixed add
    output logic sub_out, // Fixed subtract
    output logic [15:0] boolean_class_level_out, // Boolean ops
    output logic hw_right_out, // Half dest right
    output logic hw_clr_arith_reg_out, // Clear arith_reg
    output logic hw_set_ones_out, // Other half to ones
    output logic hw_swap_out, // Swap source halves
    output logic acc_operand_compare_out, // Operand compare
    output logic acc_direct_out, // Compare memory word
    output logic zero_compare_group_out, // Zero compare group
    output logic zero_cmp_mem_out, // Skip on memory
    output logic masked_logical_compare_out, // Masked compare
    output logic [3:0] mask_action_out, // Masked-bit action
    output logic mask_mem_out, // Mask from memory
    output logic mask_swap_out, // Swap mask halves
    output logic [2:0] cond_out, // Skip/jump condition
    output logic io_transfer_instr_out, // I/O command level
    output logic [7:0] io_op_out, // I/O instruction
    output logic io_block_out, // Composite block
    output logic io_cond_out, // Composite conditions
    output logic [6:0] io_dev_sel_out // Device select
);

    icd_pkg::icd_state_s st_q;
    icd_pkg::icd_state_s st_d;

    // Three bits to one-hot of eight
    function automatic logic [7:0] icd_oct(input logic [2:0] v);
        return 8'h01 << v;
    endfunction

    // Two bits to one-hot of four
    function automatic logic [3:0] icd_q4(input logic [1:0] v);
        return 4'h1 << v;
    endfunction

    // Op-code tree: class levels gate every lower decoder except the bit-6 rounding and multiply gates
    function automatic icd_pkg::icd_dec_s icd_decode(
        input logic [0:12] ir,
        input logic armed,
        input logic user,
        input logic uio,
        input logic ill
    );
        icd_pkg::icd_dec_s d;
        logic [7:0] c;
        logic [7:0] s;
        logic [7:0] o;
        logic user_iot;
        logic fp;
        logic as;
        d = '0;
        c = icd_oct(ir[0:2]);
        s = icd_oct(ir[3:5]);
        o = icd_oct(ir[6:8]);
        d.cls = c;
        // User I/O without permission traps instead
        user_iot = c[7] & user & ~uio;
        d.unimplemented_user_op = (c[0] & armed) | ill | user_iot;
        // Class 001: float, char ops, unused
        d.normalize_round_gate = ir[6];
        d.unused = c[1] & (s[0] | s[1] | s[2] |
            (s[7] & (ir[6:8] < `ICD_FSC_CODE)));
        d.fsc = c[1] & s[7] & (ir[6:8] == `ICD_FSC_CODE);
        d.chr_op = (c[1] & s[7]) ? o[7:3] : 5'h00;
        fp = c[1] & ir[3];
        d.fp_op = fp ? icd_q4(ir[4:5]) : 4'h0;
        // Class 2XX groups
        d.fullword = c[2] & (s[0] | s[1]);
        d.swap = d.fullword & ir[5];
        d.negate = d.fullword & ir[6];
        d.mul = c[2] & s[2];
        d.div = c[2] & s[3];
        d.md = c[2] & (ir[3:4] == 2'h1);
        d.div_int = d.div & ~ir[6];
        d.div_frac = d.div & ir[6];
        d.mul_frac_gate = ir[6];
        d.mul_int_gate = ~ir[6];
        d.shift = (c[2] & s[4]) ? o : 8'h00;
        d.misc = (c[2] & s[5]) ? o : 8'h00;
        d.jump = (c[2] & s[6]) ? o : 8'h00;
        d.jump_restore_instr = d.misc[`ICD_JUMP_RESTORE_INSTR_IDX] & ~d.unimplemented_user_op;
        d.jump_any = |(d.jump & `ICD_JUMP_ANY_MASK);
        d.store_misc = |(d.jump & `ICD_STORE_MISC_MASK);
        as = c[2] & s[7];
        d.add = as & ~ir[6];
        d.sub = as & ir[6];
        // Shared mode decoder for all basic-format users
        if (fp | d.fullword | d.md | as | c[4] | c[5]) begin
            d.mode = icd_q4(ir[7:8]);
        end
        // Boolean class
        d.boole = c[4] ? (16'h0001 << ir[3:6]) : 16'h0000;
        // Half-word class
        d.hw_right = c[5] & ir[3];
        d.hw_clr_ar = c[5] & (ir[4] | ir[5]);
        d.hw_set_ones = c[5] & ir[4] & ~ir[5];
        d.hw_swap = c[5] & ir[6];
        // Arithmetic compare
        d.acc_operand_compare = c[3] & (ir[3:4] == 2'h0);
        d.acc_operand_compare_direct = d.acc_operand_compare & ir[5];
        d.zero_compare_group = c[3] & (ir[3:4] != 2'h0);
        d.zero_compare_group_mem = d.zero_compare_group & ir[5];
        // Masked logical compare
        d.masked_logical_compare = c[6];
        d.mask_act = c[6] ? icd_q4(ir[3:4]) : 4'h0;
        d.mask_mem = c[6] & ir[5];
        d.mask_swap = c[6] & ir[8];
        // Condition: bit 8 term only for arithmetic compare
        d.cond[2] = ir[8] & (d.acc_operand_compare | d.zero_compare_group);
        d.cond[1:0] = (c[3] | c[6]) ? ir[6:7] : 2'h0;
        // I/O class
        d.io_transfer_instr = c[7] & ~user_iot;
        d.iot_op = d.io_transfer_instr ? icd_oct(ir[10:12]) : 8'h00;
        d.iot_blk = |(d.iot_op & `ICD_IOT_BLK_MASK);
        d.iot_cond = |(d.iot_op & `ICD_IOT_COND_MASK);
        d.dev_sel = d.io_transfer_instr ? ir[3:9] : 7'h00;
        return d;
    endfunction

    // Next state: bus, register loads, decode of the new contents
    always_comb begin
        st_d = st_q;
        st_d.rdata = 32'h0;
        if (bus_wr_in) begin
            if (bus_addr_in == `ICD_OFF_CTRL) begin
                st_d.user = bus_wdata_in[`ICD_CTRL_USER_BIT];
                st_d.uio = bus_wdata_in[`ICD_CTRL_UIO_BIT];
            end else if (bus_addr_in == `ICD_OFF_IR) begin
                st_d.ir = bus_wdata_in[12:0];
                st_d.armed = 1'b1;
            end
        end
        // Clear drops the arming flop until a new code
        if (ir_clear_in) begin
            st_d.ir = `ICD_IR_RST;
            st_d.armed = 1'b0;
        end
        if (ir_load_in) begin
            st_d.ir = ir_code_in;
            st_d.armed = 1'b1;
        end
        // Read word appears one cycle after the strobe
        if (bus_rd_in) begin
            if (bus_addr_in == `ICD_OFF_CTRL) begin
                st_d.rdata = {`ICD_PAD_CTRL, st_q.uio, st_q.user};
            end else if (bus_addr_in == `ICD_OFF_IR) begin
                st_d.rdata = {`ICD_PAD_IR, st_q.ir};
            end else if (bus_addr_in == `ICD_OFF_STAT) begin
                st_d.rdata = {`ICD_PAD_STAT, st_q.armed,
                    st_q.dec.unimplemented_user_op, st_q.dec.cls};
            end
        end
        if (sys_rst_in) begin
            st_d = '0;
            st_d.user = `ICD_CTRL_USER_RST;
            st_d.uio = `ICD_CTRL_UIO_RST;
            st_d.ir = `ICD_IR_RST;
        end
        // Levels track the register, aligned with it
        st_d.dec = icd_decode(st_d.ir, st_d.armed, st_d.user,
            st_d.uio, illegal_in & ~sys_rst_in);
    end

    // State register
    always_ff @(posedge sys_clk_in) begin
        st_q <= st_d;
    end

    // Outputs straight from the state flops
    assign bus_rdata_out = st_q.rdata;
    assign instruction_reg_out = st_q.ir;
    assign class_out = st_q.dec.cls;
    assign unimplemented_user_op_out = st_q.dec.unimplemented_user_op;
    assign unused_op_out = st_q.dec.unused;
    assign fp_op_out = st_q.dec.fp_op;
    assign char_op_out = st_q.dec.chr_op;
    assign float_scale_out = st_q.dec.fsc;
    assign normalize_round_gate_out = st_q.dec.normalize_round_gate;
    assign mode_out = st_q.dec.mode;
    assign fullword_out = st_q.dec.fullword;
    assign swap_out = st_q.dec.swap;
    assign negate_out = st_q.dec.negate;
    assign mul_out = st_q.dec.mul;
    assign div_out = st_q.dec.div;
    assign mul_div_out = st_q.dec.md;
    assign div_int_out = st_q.dec.div_int;
    assign div_frac_out = st_q.dec.div_frac;
    assign mul_frac_gate_out = st_q.dec.mul_frac_gate;
    assign mul_int_gate_out = st_q.dec.mul_int_gate;
    assign shift_op_out = st_q.dec.shift;
    assign misc_op_out = st_q.dec.misc;
    assign jump_restore_instr_out = st_q.dec.jump_restore_instr;
    assign jump_group_out = st_q.dec.jump;
    assign jump_any_out = st_q.dec.jump_any;
    assign store_misc_out = st_q.dec.store_misc;
    assign add_out = st_q.dec.add;
    assign sub_out = st_q.dec.sub;
    assign boolean_class_level_out = st_q.dec.boole;
    assign hw_right_out = st_q.dec.hw_right;
    assign hw_clr_arith_reg_out = st_q.dec.hw_clr_ar;
    assign hw_set_ones_out = st_q.dec.hw_set_ones;
    assign hw_swap_out = st_q.dec.hw_swap;
    assign acc_operand_compare_out = st_q.dec.acc_operand_compare;
    assign acc_direct_out = st_q.dec.acc_operand_compare_direct;
    assign zero_compare_group_out = st_q.dec.zero_compare_group;
    assign zero_cmp_mem_out = st_q.dec.zero_compare_group_mem;
    assign masked_logical_compare_out = st_q.dec.masked_logical_compare;
    assign mask_action_out = st_q.dec.mask_act;
    assign mask_mem_out = st_q.dec.mask_mem;
    assign mask_swap_out = st_q.dec.mask_swap;
    assign cond_out = st_q.dec.cond;
    assign io_transfer_instr_out = st_q.dec.io_transfer_instr;
    assign io_op_out = st_q.dec.iot_op;
    assign io_block_out = st_q.dec.iot_blk;
    assign io_cond_out = st_q.dec.iot_cond;
    assign io_dev_sel_out = st_q.dec.dev_sel;

    // Checks on the decoded levels
    default clocking icd_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    a_class_one_hot:
    assert property ($onehot(class_out) &&
        class_out[instruction_reg_out[0:2]])
    else $error("class level not one-hot of top bits");

    a_idle_no_trap:
    assert property (ir_clear_in && !ir_load_in && !illegal_in &&
        !bus_wr_in |=> !unimplemented_user_op_out)
    else $error("trap raised while register clear");

    a_illegal_trap:
    assert property (illegal_in |=> unimplemented_user_op_out)
    else $error("illegal attempt did not trap");

    a_user_io_blocked:
    assert property (class_out[7] && st_q.user && !st_q.uio |->
        !io_transfer_instr_out && io_op_out == 8'h00 &&
        unimplemented_user_op_out)
    else $error("user I/O not blocked");

    a_device_select:
    assert property (io_transfer_instr_out |->
        io_dev_sel_out == instruction_reg_out[3:9] &&
        $onehot(io_op_out))
    else $error("device select mismatch");

    a_class1_unused:
    assert property (class_out[1] && instruction_reg_out[3:5] < 3'h3
        |-> unused_op_out && fp_op_out == 4'h0 && char_op_out == 5'h00)
    else $error("unused float codes decoded");

    a_round_free:
    assert property (normalize_round_gate_out == instruction_reg_out[6])
    else $error("rounding gate not bit 6");

    a_jump_restore_instr_gate:
    assert property (jump_restore_instr_out |->
        !unimplemented_user_op_out && misc_op_out == 8'h10)
    else $error("jump-restore raised during trap");

    a_cond_bit8:
    assert property (masked_logical_compare_out |-> !cond_out[2])
    else $error("bit 8 term in logical compare");

    a_levels_stable:
    assert property (!ir_load_in && !ir_clear_in && !bus_wr_in &&
        !illegal_in && !$past(illegal_in) |=> $stable(class_out) &&
        $stable(mode_out) && $stable(io_op_out))
    else $error("levels moved while register held");

    a_read_latency:
    assert property (bus_rd_in && bus_addr_in == `ICD_OFF_IR |=>
        bus_rdata_out[12:0] == $past(instruction_reg_out))
    else $error("read data not one cycle after strobe");

    a_read_idle_zero:
    assert property (!bus_rd_in |=> bus_rdata_out == 32'h0)
    else $error("read data outside its cycle");

    a_boole_one_hot:
    assert property (class_out[4] |-> $onehot(boolean_class_level_out) &&
        boolean_class_level_out[instruction_reg_out[3:6]])
    else $error("Boolean level not one-hot of bits 3-6");

    a_mul_div_share:
    assert property (mul_div_out == (mul_out || div_out))
    else $error("shared mul/div level mismatch");

    a_div_levels:
    assert property ((div_int_out || div_frac_out) == div_out &&
        !(div_int_out && div_frac_out))
    else $error("divide levels not one of two");

    a_jump_shared:
    assert property (jump_any_out || store_misc_out |->
        jump_group_out != 8'h00)
    else $error("shared jump level without jump group");

    a_hw_set_clear:
    assert property (hw_set_ones_out |-> hw_clr_arith_reg_out &&
        class_out[5])
    else $error("set ones without clear");

    a_cmp_split:
    assert property (class_out[3] |->
        acc_operand_compare_out != zero_compare_group_out)
    else $error("compare class not split in two");

    a_fw_mode:
    assert property (fullword_out |-> $onehot(mode_out) &&
        mode_out[instruction_reg_out[7:8]])
    else $error("full-word mode not from bits 7-8");

    c_io_decode: cover property (io_transfer_instr_out ##1 class_out[2]);
    c_trap: cover property (class_out[0] && unimplemented_user_op_out);
    c_jump: cover property (jump_any_out && store_misc_out);
    c_boole: cover property (boolean_class_level_out[15]);

endmodule

// File: include/icd_consts.svh
`ifndef ICD_CONSTS_SVH
`define ICD_CONSTS_SVH

// Register byte offsets
`define ICD_OFF_CTRL 4'h0
`define ICD_OFF_IR 4'h4
`define ICD_OFF_STAT 4'h8

// Control register fields
`define ICD_CTRL_USER_BIT 0
`define ICD_CTRL_UIO_BIT 1

// Reset values
`define ICD_CTRL_USER_RST 1'b0
`define ICD_CTRL_UIO_RST 1'b0
`define ICD_IR_RST 13'h0000

// Pads for read words
`define ICD_PAD_CTRL 30'h0
`define ICD_PAD_IR 19'h0
`define ICD_PAD_STAT 22'h0

// Class 001 codes for bits 6-8 under 111
`define ICD_FSC_CODE 3'h2
`define ICD_CHR_FIRST 3'h2

// Jump group members that jump, and that store the flags
`define ICD_JUMP_ANY_MASK 8'hf9
`define ICD_STORE_MISC_MASK 8'h31
// Index of jump-and-restore in the miscellaneous group
`define ICD_JUMP_RESTORE_INSTR_IDX 3'h4

// I/O composites: block transfers, conditions tests
`define ICD_IOT_BLK_MASK 8'h05
`define ICD_IOT_COND_MASK 8'ha0

`endif

// File: include/icd_pkg.sv
package icd_pkg;

    // Decoded gating levels
    typedef struct packed {
        logic [7:0] cls;
        logic unimplemented_user_op;
        logic unused;
        logic [3:0] fp_op;
        logic [4:0] chr_op;
        logic fsc;
        logic normalize_round_gate;
        logic [3:0] mode;
        logic fullword;
        logic swap;
        logic negate;
        logic mul;
        logic div;
        logic md;
        logic div_int;
        logic div_frac;
        logic mul_frac_gate;
        logic mul_int_gate;
        logic [7:0] shift;
        logic [7:0] misc;
        logic jump_restore_instr;
        logic [7:0] jump;
        logic jump_any;
        logic store_misc;
        logic add;
        logic sub;
        logic [15:0] boole;
        logic hw_right;
        logic hw_clr_ar;
        logic hw_set_ones;
        logic hw_swap;
        logic acc_operand_compare;
        logic acc_operand_compare_direct;
        logic zero_compare_group;
        logic zero_compare_group_mem;
        logic masked_logical_compare;
        logic [3:0] mask_act;
        logic mask_mem;
        logic mask_swap;
        logic [2:0] cond;
        logic io_transfer_instr;
        logic [7:0] iot_op;
        logic iot_blk;
        logic iot_cond;
        logic [6:0] dev_sel;
    } icd_dec_s;

    // Whole state of the decoder
    typedef struct packed {
        logic user;
        logic uio;
        logic [0:12] ir;
        logic armed;
        icd_dec_s dec;
        logic [31:0] rdata;
    } icd_state_s;

endpackage

// File: verif/icd_ctrl_model.sv
// Stand-in for the main control sequence that loads op-codes
module icd_ctrl_model (
    input wire logic clk_in, // Processor clock
    output logic load_out, // Load pulse
    output logic [0:12] code_out, // Op-code bits
    output logic clear_out, // Clear pulse
    output logic illegal_out // User illegal attempt
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle lines at time zero
    initial begin
        load_out = 1'b0;
        code_out = 13'h0000;
        clear_out = 1'b0;
        illegal_out = 1'b0;
    end

    // One-cycle load, code lines invert after so stale codes show
    task automatic load(input logic [0:12] c);
        @(posedge clk_in);
        load_out <= 1'b1;
        code_out <= c;
        @(posedge clk_in);
        load_out <= 1'b0;
        code_out <= ~c;
        #1;
    endtask

    // One-cycle clear, leaves register awaiting a code
    task automatic clear();
        @(posedge clk_in);
        clear_out <= 1'b1;
        @(posedge clk_in);
        clear_out <= 1'b0;
        #1;
    endtask

    // One-cycle illegal attempt report
    task automatic flag_illegal();
        @(posedge clk_in);
        illegal_out <= 1'b1;
        @(posedge clk_in);
        illegal_out <= 1'b0;
        #1;
    endtask
endmodule

// File: verif/tb_instruction_class_decoder.sv
`include "icd_consts.svh"
module tb_instruction_class_decoder;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk_in, sys_rst_in, bus_wr_in, bus_rd_in;
    logic ir_load_in, ir_clear_in, illegal_in;
    logic [3:0] bus_addr_in, fp_op_out, mode_out, mask_action_out;
    logic [31:0] bus_wdata_in, bus_rdata_out;
    logic [0:12] ir_code_in, instruction_reg_out;
    logic [7:0] class_out, shift_op_out, misc_op_out, jump_group_out;
    logic [7:0] io_op_out;
    logic [4:0] char_op_out;
    logic [15:0] boolean_class_level_out;
    logic [2:0] cond_out;
    logic [6:0] io_dev_sel_out;
    logic unimplemented_user_op_out, unused_op_out, float_scale_out;
    logic normalize_round_gate_out, fullword_out, swap_out, negate_out;
    logic mul_out, div_out, mul_div_out, div_int_out, div_frac_out;
    logic mul_frac_gate_out, mul_int_gate_out, jump_restore_instr_out;
    logic jump_any_out, store_misc_out, add_out, sub_out, hw_right_out;
    logic hw_clr_arith_reg_out, hw_set_ones_out, hw_swap_out;
    logic acc_operand_compare_out, acc_direct_out, zero_compare_group_out;
    logic zero_cmp_mem_out, masked_logical_compare_out, mask_mem_out;
    logic mask_swap_out, io_transfer_instr_out, io_block_out, io_cond_out;
    int err_total = 0;
    int samples_checked = 0;

    icd_decoder u_icd_decoder (.*);
    icd_ctrl_model u_icd_ctrl_model (.clk_in(sys_clk_in),
        .load_out(ir_load_in), .code_out(ir_code_in),
        .clear_out(ir_clear_in), .illegal_out(illegal_in));

    // Free-running 100 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_sim();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Bus master: one-cycle strobes, read data in the next cycle only
    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        bus_wr_in <= 1'b1;
        bus_addr_in <= a;
        bus_wdata_in <= d;
        @(posedge sys_clk_in);
        bus_wr_in <= 1'b0;
        #1;
    endtask

    task automatic bus_read(input logic [3:0] a, input logic [31:0] e);
        @(posedge sys_clk_in);
        bus_rd_in <= 1'b1;
        bus_addr_in <= a;
        @(posedge sys_clk_in);
        bus_rd_in <= 1'b0;
        #1;
        chk("rdata", e, bus_rdata_out);
    endtask

    task automatic ld(input logic [0:12] c);
        u_icd_ctrl_model.load(c);
    endtask

    // Every class value, trap arming and clearing
    task automatic sc_classes();
        for (int c = 0; c < 8; c++) begin
            ld({3'(c), 10'h000});
            chk("class", 32'h1 << c, class_out);
        end
        ld(13'h0000);
        chk("trap", 1, unimplemented_user_op_out);
        u_icd_ctrl_model.clear();
        chk("trap idle", 0, unimplemented_user_op_out);
        ld({3'd4, 10'h000});
        u_icd_ctrl_model.flag_illegal();
        chk("trap ill", 1, unimplemented_user_op_out);
        @(posedge sys_clk_in);
        #1;
        chk("trap end", 0, unimplemented_user_op_out);
    endtask

    // I/O class: ops, composites, device select, user blocking
    task automatic sc_io();
        for (int i = 0; i < 8; i++) begin
            ld({3'd7, 7'h5a, 3'(i)});
            chk("io lvl", 1, io_transfer_instr_out);
            chk("io op", 32'h1 << i, io_op_out);
            chk("io blk", `ICD_IOT_BLK_MASK >> i & 1, io_block_out);
            chk("io cnd", `ICD_IOT_COND_MASK >> i & 1, io_cond_out);
            chk("dev", 7'h5a, io_dev_sel_out);
        end
        bus_write(`ICD_OFF_CTRL, 32'h1);
        ld({3'd7, 7'h21, 3'd1});
        chk("uio lvl", 0, io_transfer_instr_out);
        chk("uio trap", 1, unimplemented_user_op_out);
        bus_write(`ICD_OFF_CTRL, 32'h3);
        ld({3'd7, 7'h21, 3'd1});
        chk("pio lvl", 1, io_transfer_instr_out);
        chk("pio trap", 0, unimplemented_user_op_out);
        bus_write(`ICD_OFF_CTRL, 32'h0);
    endtask

    // Class 001: unused digits, character ops, float ops, rounding
    task automatic sc_float();
        for (int d = 0; d < 3; d++) begin
            ld({3'd1, 3'(d), 3'd5, 4'h0});
            chk("unused", 1, unused_op_out);
            chk("no fp", 0, fp_op_out);
        end
        for (int i = 0; i < 8; i++) begin
            ld({3'd1, 3'd7, 3'(i), 4'h0});
            chk("unused7", i < 2, unused_op_out);
            chk("fsc", i == 2, float_scale_out);
            chk("chr", i > 2 ? 32'h1 << (i - 3) : 0, char_op_out);
        end
        ld({3'd1, 3'b110, 3'b011, 4'h0});
        chk("fp op", 4'h4, fp_op_out);
        chk("fp mode", 4'h8, mode_out);
        chk("round0", 0, normalize_round_gate_out);
        ld({3'd4, 3'd0, 3'b100, 4'h0});
        chk("round1", 1, normalize_round_gate_out);
    endtask

    // Class 2XX groups
    task automatic sc_fixed();
        ld({3'd2, 3'b001, 3'b010, 4'h0});
        chk("fullword", 1, fullword_out);
        chk("swap", 1, swap_out);
        chk("negate", 0, negate_out);
        chk("fw mode", 4'h4, mode_out);
        ld({3'd2, 3'b010, 3'b100, 4'h0});
        chk("mul", 3'b101, {mul_out, div_out, mul_div_out});
        chk("mul gates", 2'b10, {mul_frac_gate_out, mul_int_gate_out});
        chk("md mode", 4'h1, mode_out);
        ld({3'd2, 3'b011, 3'b011, 4'h0});
        chk("div", 3'b011, {mul_out, div_out, mul_div_out});
        chk("div lv", 2'b10, {div_int_out, div_frac_out});
        chk("int gate", 1, mul_int_gate_out);
        for (int i = 0; i < 8; i++) begin
            ld({3'd2, 3'd4, 3'(i), 4'h0});
            chk("shift", 32'h1 << i, shift_op_out);
            ld({3'd2, 3'd5, 3'(i), 4'h0});
            chk("misc", 32'h1 << i, misc_op_out);
            chk("jump_restore_instr", i == 4, jump_restore_instr_out);
            ld({3'd2, 3'd6, 3'(i), 4'h0});
            chk("jump", 32'h1 << i, jump_group_out);
            chk("jany", `ICD_JUMP_ANY_MASK >> i & 1, jump_any_out);
            chk("jst", `ICD_STORE_MISC_MASK >> i & 1, store_misc_out);
        end
        ld({3'd2, 3'd5, 3'd4, 4'h0});
        u_icd_ctrl_model.flag_illegal();
        chk("jump_restore_instr trap", 0, jump_restore_instr_out);
        ld({3'd2, 3'd7, 3'b101, 4'h0});
        chk("addsub", 2'b01, {add_out, sub_out});
        chk("as mode", 4'h2, mode_out);
    endtask

    // Boolean and half-word classes
    task automatic sc_boole_hw();
        for (int i = 0; i < 16; i++) begin
            ld({3'd4, 4'(i), 2'b01, 4'h0});
            chk("boole", 32'h1 << i, boolean_class_level_out);
            chk("bl mode", 4'h2, mode_out);
        end
        ld({3'd5, 3'b110, 3'b111, 4'h0});
        chk("hw a", 8'hf8, {hw_right_out, hw_clr_arith_reg_out,
            hw_set_ones_out, hw_swap_out, mode_out});
        ld({3'd5, 3'b001, 3'b000, 4'h0});
        chk("hw b", 8'h41, {hw_right_out, hw_clr_arith_reg_out,
            hw_set_ones_out, hw_swap_out, mode_out});
    endtask

    // Arithmetic and masked logical compare
    task automatic sc_compare();
        ld({3'd3, 3'b001, 3'b111, 4'h0});
        chk("acc_operand_compare", 3'b110, {acc_operand_compare_out, acc_direct_out,
            zero_compare_group_out});
        chk("cond a", 3'b111, cond_out);
        ld({3'd3, 3'b110, 3'b001, 4'h0});
        chk("zero_compare_group", 3'b010, {acc_operand_compare_out,
            zero_compare_group_out, zero_cmp_mem_out});
        chk("cond b8", 3'b100, cond_out);
        ld({3'd6, 3'b101, 3'b111, 4'h0});
        chk("masked_logical_compare", 3'b111, {masked_logical_compare_out, mask_mem_out,
            mask_swap_out});
        chk("mact", 4'h4, mask_action_out);
        chk("cond l", 3'b011, cond_out);
        ld({3'd6, 3'b000, 3'b001, 4'h0});
        chk("cond l8", 0, cond_out);
        chk("mswap", 1, mask_swap_out);
    endtask

    // Register port, unmapped place, stability while held
    task automatic sc_bus();
        bus_write(`ICD_OFF_IR, 32'h1c00);
        chk("bus class", 8'h80, class_out);
        bus_read(`ICD_OFF_STAT, {22'h0, 2'b10, 8'h80});
        @(posedge sys_clk_in);
        #1;
        chk("rdata idle", 0, bus_rdata_out);
        chk("ir", 13'h1c00, instruction_reg_out);
        bus_read(`ICD_OFF_IR, 32'h1c00);
        bus_write(`ICD_OFF_CTRL, 32'h3);
        bus_write(4'hc, 32'h0);
        bus_read(4'hc, 32'h0);
        bus_read(`ICD_OFF_CTRL, 32'h3);
        bus_write(`ICD_OFF_CTRL, 32'h0);
        repeat (3) @(posedge sys_clk_in);
        #1;
        chk("held", 8'h80, class_out);
    endtask

    // Bound on the whole run
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        err_total++;
        end_sim();
    end

    // Reset, then the scenarios in turn
    initial begin
        sys_rst_in = 1'b1;
        bus_wr_in = 1'b0;
        bus_rd_in = 1'b0;
        bus_addr_in = 4'h0;
        bus_wdata_in = 32'h0;
        repeat (2) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        #1;
        chk("rst class", 8'h01, class_out);
        chk("rst trap", 0, unimplemented_user_op_out);
        sc_classes();
        sc_io();
        sc_float();
        sc_fixed();
        sc_boole_hw();
        sc_compare();
        sc_bus();
        end_sim();
    end
endmodule
